/* byte_memory_model.sv */
`timescale 1ns/100ps
`default_nettype none

// byte-wide memory on the far side; ack_delay stretches each answer
module byte_memory_model (
  input  wire logic                 clk_sys,
  input  wire logic                 reset_n,
  input  wire mem_ref_pkg::mem_cmd_s mem_cmd,
  input  wire logic [3:0]           ack_delay,
  output logic                      mem_ack,
  output logic [7:0]                mem_rdata
);
  logic [7:0] mem [0:65535];
  logic [3:0] wait_cnt;

  // contents survive reset, so a mid-run reset does not wipe the program
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mem_ack   <= 1'b0;
      wait_cnt  <= 4'h0;
      mem_rdata <= 8'h5a;
    end else if (mem_cmd.req && !mem_ack && wait_cnt >= ack_delay) begin
      mem_ack  <= 1'b1;
      wait_cnt <= 4'h0;
      if (mem_cmd.we) begin
        mem[mem_cmd.address] <= mem_cmd.wdata;
      end else begin
        mem_rdata <= mem[mem_cmd.address];
      end
    end else begin
      mem_ack <= 1'b0;
      // stale data is inverted so a late sample cannot pass by luck
      mem_rdata <= ~mem_rdata;
      if (mem_cmd.req && !mem_ack) begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* mem_ref_defines.svh */
`ifndef MEM_REF_DEFINES_SVH
`define MEM_REF_DEFINES_SVH

// opcode fields of the first instruction byte
`define OPC4_LOAD_DIRECT       4'h8
`define OPC4_STORE_DIRECT      4'h9
`define OPC4_ADD               4'ha
`define OPC4_SKIP_NOT_EQUAL    4'hb
`define OPC6_AND               6'h30
`define OPC6_OR                6'h34
`define OPC6_SKIP_AND_ZERO     6'h38
`define OPC6_INCREMENT_SKIP    6'h39
`define OPC6_SUBTRACT          6'h3c
`define OPC6_DECREMENT_SKIP    6'h3d
`define OPC7_LOAD_POINTER      7'h12
`define OPC7_STORE_POINTER     7'h1a

// field positions in the first instruction byte
`define OPC4_MSB               7
`define OPC4_LSB               4
`define OPC6_MSB               7
`define OPC6_LSB               2
`define OPC7_MSB               7
`define OPC7_LSB               1
`define ACC_SEL_MSB            3
`define ACC_SEL_LSB            2
`define MODE_MSB               1
`define MODE_LSB               0
`define PAGE_SEL_BIT           0

// addressing mode codes
`define MODE_BASE_PAGE         2'h0
`define MODE_CURRENT_PAGE      2'h1
`define MODE_UNDEFINED         2'h2
`define MODE_INDEXED           2'h3

// constants and reset values
`define BASE_PAGE              8'h00
`define PC_STEP                16'h0001
`define SKIP_STEP              16'h0002
`define BYTE_STEP              8'h01
`define RESET_PC               16'h0000
`define RESET_BYTE             8'h00
`define RESET_ADDR             16'h0000

`endif

/* mem_ref_pkg.sv */
package mem_ref_pkg;

  // gray codes along fetch -> displacement -> pointer -> operand -> writeback
  typedef enum logic [2:0] {
    ST_FETCH_OP   = 3'h0,
    ST_FETCH_DISP = 3'h1,
    ST_PTR_PAGE   = 3'h3,
    ST_PTR_BYTE   = 3'h2,
    ST_OPERAND    = 3'h6,
    ST_WRITEBACK  = 3'h7
  } state_e;

  typedef enum logic [3:0] {
    OP_NONE,
    OP_LOAD_DIRECT,
    OP_STORE_DIRECT,
    OP_ADD,
    OP_SKIP_NOT_EQUAL,
    OP_AND,
    OP_OR,
    OP_SKIP_AND_ZERO,
    OP_INCREMENT_SKIP_ZERO,
    OP_SUBTRACT,
    OP_DECREMENT_SKIP_ZERO,
    OP_LOAD_VIA_POINTER,
    OP_STORE_VIA_POINTER
  } op_e;

  // one held memory request towards the byte-wide memory
  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] address;
    logic [7:0]  wdata;
  } mem_cmd_s;

  typedef logic [3:0][7:0] acc_bank_t;

endpackage

/* memory_reference_instruction_unit.sv */
// Behaviour
// - mode 11: page from accumulator two, byte is accumulator three plus displacement
// - indirect: displacement points at two bytes, page first then byte
// - page-select bit puts the pointer on base page or current page
// - displacement byte is unsigned eight bits
// - program counter already advanced when the address is formed; high half is page
// - select flag picks carry or overflow for the combined output line
// - direct load copies memory to accumulator; direct store writes accumulator out
// - load via pointer fills accumulator zero from the pointed location
// - store via pointer writes accumulator zero to the pointed location
// - add puts accumulator plus memory byte into the selected accumulator
// - subtract takes memory byte from accumulator zero only
// - add and subtract update carry and overflow flags
// - AND of accumulator zero with memory byte into accumulator zero
// - inclusive OR of accumulator zero with memory byte into accumulator zero
// - increment memory byte, write back, skip two if zero
// - decrement memory byte, write back, skip two if zero
// - skip two on not-equal, or when accumulator zero AND byte is zero
// - mode 00 is page zero, mode 01 is the current page
// - indexed byte sum wraps in eight bits; page never changes
// - carry is carry out of bit 7; overflow is carry in differing from out
`include "mem_ref_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module memory_reference_instruction_unit (
  input  wire logic                   clk_sys,
  input  wire logic                   reset_n,
  input  wire logic                   mem_ack,
  input  wire logic [7:0]             mem_rdata,
  input  wire logic                   select_flag,
  output mem_ref_pkg::mem_cmd_s       mem_cmd,
  output logic [15:0]                 program_counter,
  output mem_ref_pkg::acc_bank_t      accumulators,
  output logic                        carry_flag,
  output logic                        overflow_flag,
  output logic                        carry_overflow_output_line,
  output logic                        unsupported_opcode
);

  function automatic mem_ref_pkg::op_e decode_op(input logic [7:0] b);
    logic [1:0] mode;
    mode = b[`MODE_MSB:`MODE_LSB];
    decode_op = mem_ref_pkg::OP_NONE;
    if (b[`OPC7_MSB:`OPC7_LSB] == `OPC7_LOAD_POINTER) begin
      decode_op = mem_ref_pkg::OP_LOAD_VIA_POINTER;
    end else if (b[`OPC7_MSB:`OPC7_LSB] == `OPC7_STORE_POINTER) begin
      decode_op = mem_ref_pkg::OP_STORE_VIA_POINTER;
    end else if (mode != `MODE_UNDEFINED) begin
      unique case (b[`OPC4_MSB:`OPC4_LSB])
        `OPC4_LOAD_DIRECT:    decode_op = mem_ref_pkg::OP_LOAD_DIRECT;
        `OPC4_STORE_DIRECT:   decode_op = mem_ref_pkg::OP_STORE_DIRECT;
        `OPC4_ADD:            decode_op = mem_ref_pkg::OP_ADD;
        `OPC4_SKIP_NOT_EQUAL: decode_op = mem_ref_pkg::OP_SKIP_NOT_EQUAL;
        default: begin
          unique case (b[`OPC6_MSB:`OPC6_LSB])
            `OPC6_AND:            decode_op = mem_ref_pkg::OP_AND;
            `OPC6_OR:             decode_op = mem_ref_pkg::OP_OR;
            `OPC6_SKIP_AND_ZERO:  decode_op = mem_ref_pkg::OP_SKIP_AND_ZERO;
            `OPC6_INCREMENT_SKIP: decode_op = mem_ref_pkg::OP_INCREMENT_SKIP_ZERO;
            `OPC6_SUBTRACT:       decode_op = mem_ref_pkg::OP_SUBTRACT;
            `OPC6_DECREMENT_SKIP: decode_op = mem_ref_pkg::OP_DECREMENT_SKIP_ZERO;
            default:              decode_op = mem_ref_pkg::OP_NONE;
          endcase
        end
      endcase
    end
  endfunction

  mem_ref_pkg::state_e state;
  logic [7:0]          instr;
  logic [7:0]          disp;
  logic [7:0]          ptr_page;
  logic [7:0]          ptr_byte;
  logic [7:0]          modified_byte;

  wire logic                ack = mem_cmd.req && mem_ack;
  wire mem_ref_pkg::op_e    op = decode_op(instr);
  wire mem_ref_pkg::op_e    fetched_op = decode_op(mem_rdata);
  wire logic [1:0]          addressing_mode_field = instr[`MODE_MSB:`MODE_LSB];
  wire logic [1:0]          acc_sel = instr[`ACC_SEL_MSB:`ACC_SEL_LSB];
  wire logic                page_select = instr[`PAGE_SEL_BIT];
  wire logic [7:0]          program_page_counter = program_counter[15:8];
  wire logic [7:0]          accumulator_zero = accumulators[0];
  wire logic [7:0]          index_page_accumulator = accumulators[2];
  wire logic [7:0]          index_byte_accumulator = accumulators[3];
  wire logic [7:0]          selected_accumulator = accumulators[acc_sel];
  wire logic                indirect = (op == mem_ref_pkg::OP_LOAD_VIA_POINTER) ||
                                       (op == mem_ref_pkg::OP_STORE_VIA_POINTER);
  wire logic                fetched_indirect =
                              (fetched_op == mem_ref_pkg::OP_LOAD_VIA_POINTER) ||
                              (fetched_op == mem_ref_pkg::OP_STORE_VIA_POINTER);

  // effective address; the counter has passed both instruction bytes already
  wire logic [7:0]  indexed_byte = index_byte_accumulator + disp;
  wire logic [15:0] effective_address =
    (addressing_mode_field == `MODE_INDEXED)      ? {index_page_accumulator, indexed_byte} :
    (addressing_mode_field == `MODE_CURRENT_PAGE) ? {program_page_counter, disp} :
                                                    {`BASE_PAGE, disp};
  wire logic [15:0] pointer_address =
    {(page_select ? program_page_counter : `BASE_PAGE), disp};
  // the pointer's second byte stays on the pointer's page
  wire logic [15:0] pointer_next = {pointer_address[15:8], pointer_address[7:0] + `BYTE_STEP};
  wire logic [15:0] operand_address = indirect ? {ptr_page, ptr_byte} : effective_address;

  wire logic store_op = (op == mem_ref_pkg::OP_STORE_DIRECT) ||
                        (op == mem_ref_pkg::OP_STORE_VIA_POINTER);
  wire logic rmw_op   = (op == mem_ref_pkg::OP_INCREMENT_SKIP_ZERO) ||
                        (op == mem_ref_pkg::OP_DECREMENT_SKIP_ZERO);

  wire logic [15:0] next_address =
    (state == mem_ref_pkg::ST_FETCH_OP)   ? program_counter :
    (state == mem_ref_pkg::ST_FETCH_DISP) ? program_counter :
    (state == mem_ref_pkg::ST_PTR_PAGE)   ? pointer_address :
    (state == mem_ref_pkg::ST_PTR_BYTE)   ? pointer_next : operand_address;
  wire logic       next_we = ((state == mem_ref_pkg::ST_OPERAND) && store_op) ||
                             (state == mem_ref_pkg::ST_WRITEBACK);
  wire logic [7:0] next_wdata =
    (state == mem_ref_pkg::ST_WRITEBACK)       ? modified_byte :
    (op == mem_ref_pkg::OP_STORE_VIA_POINTER)  ? accumulator_zero :
                                                 selected_accumulator;

  // arithmetic: subtract is accumulator zero plus the complement plus one
  wire logic       is_sub = (op == mem_ref_pkg::OP_SUBTRACT);
  wire logic [7:0] alu_a = is_sub ? accumulator_zero : selected_accumulator;
  wire logic [7:0] alu_b = is_sub ? ~mem_rdata : mem_rdata;
  wire logic [8:0] alu_sum = {1'b0, alu_a} + {1'b0, alu_b} + {8'h00, is_sub};
  wire logic [7:0] alu_low = {1'b0, alu_a[6:0]} + {1'b0, alu_b[6:0]} + {7'h00, is_sub};
  wire logic       next_carry = alu_sum[8];
  wire logic       next_overflow = alu_low[7] ^ alu_sum[8];

  wire logic [7:0] rmw_value =
    (op == mem_ref_pkg::OP_INCREMENT_SKIP_ZERO) ? mem_rdata + `BYTE_STEP :
                                                  mem_rdata - `BYTE_STEP;

  wire logic skip_taken =
    ((op == mem_ref_pkg::OP_SKIP_NOT_EQUAL) && (selected_accumulator != mem_rdata)) ||
    ((op == mem_ref_pkg::OP_SKIP_AND_ZERO) && ((accumulator_zero & mem_rdata) == 8'h00));

  wire logic operand_done = ack && (state == mem_ref_pkg::ST_OPERAND);
  wire logic acc_we = operand_done && !store_op && !rmw_op &&
                      (op != mem_ref_pkg::OP_SKIP_NOT_EQUAL) &&
                      (op != mem_ref_pkg::OP_SKIP_AND_ZERO);
  wire logic [1:0] acc_idx = ((op == mem_ref_pkg::OP_LOAD_DIRECT) ||
                              (op == mem_ref_pkg::OP_ADD)) ? acc_sel : 2'h0;
  wire logic [7:0] acc_wdata =
    (op == mem_ref_pkg::OP_ADD)      ? alu_sum[7:0] :
    (op == mem_ref_pkg::OP_SUBTRACT) ? alu_sum[7:0] :
    (op == mem_ref_pkg::OP_AND)      ? accumulator_zero & mem_rdata :
    (op == mem_ref_pkg::OP_OR)       ? accumulator_zero | mem_rdata :
                                       mem_rdata;
  wire logic flags_we = operand_done && ((op == mem_ref_pkg::OP_ADD) || is_sub);

  wire logic fetch_ack = ack && ((state == mem_ref_pkg::ST_FETCH_OP) ||
                                 (state == mem_ref_pkg::ST_FETCH_DISP));
  wire logic rmw_zero  = ack && (state == mem_ref_pkg::ST_WRITEBACK) && (modified_byte == 8'h00);
  wire logic [15:0] next_pc =
    fetch_ack                                ? program_counter + `PC_STEP :
    (rmw_zero || (operand_done && skip_taken)) ? program_counter + `SKIP_STEP :
                                               program_counter;

  mem_ref_pkg::state_e next_state;
  always_comb begin
    next_state = state;
    if (ack) begin
      unique case (state)
        mem_ref_pkg::ST_FETCH_OP:   next_state = (fetched_op == mem_ref_pkg::OP_NONE) ?
                                      mem_ref_pkg::ST_FETCH_OP : mem_ref_pkg::ST_FETCH_DISP;
        mem_ref_pkg::ST_FETCH_DISP: next_state = indirect ?
                                      mem_ref_pkg::ST_PTR_PAGE : mem_ref_pkg::ST_OPERAND;
        mem_ref_pkg::ST_PTR_PAGE:   next_state = mem_ref_pkg::ST_PTR_BYTE;
        mem_ref_pkg::ST_PTR_BYTE:   next_state = mem_ref_pkg::ST_OPERAND;
        mem_ref_pkg::ST_OPERAND:    next_state = rmw_op ?
                                      mem_ref_pkg::ST_WRITEBACK : mem_ref_pkg::ST_FETCH_OP;
        mem_ref_pkg::ST_WRITEBACK:  next_state = mem_ref_pkg::ST_FETCH_OP;
        default:                    next_state = mem_ref_pkg::ST_FETCH_OP;
      endcase
    end
  end

  // request is raised one cycle after the previous ack so address and data settle first
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state   <= mem_ref_pkg::ST_FETCH_OP;
      mem_cmd <= '0;
    end else if (!mem_cmd.req) begin
      mem_cmd <= '{req: 1'b1, we: next_we, address: next_address, wdata: next_wdata};
    end else if (mem_ack) begin
      mem_cmd.req <= 1'b0;
      state       <= next_state;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      instr         <= `RESET_BYTE;
      disp          <= `RESET_BYTE;
      ptr_page      <= `RESET_BYTE;
      ptr_byte      <= `RESET_BYTE;
      modified_byte <= `RESET_BYTE;
    end else if (ack) begin
      if (state == mem_ref_pkg::ST_FETCH_OP) instr <= mem_rdata;
      if (state == mem_ref_pkg::ST_FETCH_DISP) disp <= mem_rdata;
      if (state == mem_ref_pkg::ST_PTR_PAGE) ptr_page <= mem_rdata;
      if (state == mem_ref_pkg::ST_PTR_BYTE) ptr_byte <= mem_rdata;
      if (state == mem_ref_pkg::ST_OPERAND) modified_byte <= rmw_value;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      program_counter    <= `RESET_PC;
      unsupported_opcode <= 1'b0;
    end else begin
      program_counter    <= next_pc;
      unsupported_opcode <= ack && (state == mem_ref_pkg::ST_FETCH_OP) &&
                            (fetched_op == mem_ref_pkg::OP_NONE);
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      accumulators               <= '0;
      carry_flag                 <= 1'b0;
      overflow_flag              <= 1'b0;
      carry_overflow_output_line <= 1'b0;
    end else begin
      if (acc_we) accumulators[acc_idx] <= acc_wdata;
      if (flags_we) begin
        carry_flag    <= next_carry;
        overflow_flag <= next_overflow;
      end
      // follows the flags one cycle later
      carry_overflow_output_line <= select_flag ? overflow_flag : carry_flag;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  wire logic direct_operand_req = mem_cmd.req && (state == mem_ref_pkg::ST_OPERAND) && !indirect;

  property p_indexed_address;
    direct_operand_req && (addressing_mode_field == `MODE_INDEXED) |->
      mem_cmd.address == {accumulators[2], 8'(accumulators[3] + disp)};
  endproperty
  a_indexed_address: assert property (p_indexed_address) else $error("indexed address wrong");

  property p_page_modes;
    direct_operand_req && (addressing_mode_field != `MODE_INDEXED) |->
      mem_cmd.address[7:0] == disp &&
      mem_cmd.address[15:8] == (addressing_mode_field[0] ? program_counter[15:8] : 8'h00);
  endproperty
  a_page_modes: assert property (p_page_modes) else $error("page mode address wrong");

  property p_pointer_pair;
    (state == mem_ref_pkg::ST_PTR_PAGE) && mem_cmd.req && mem_ack |=>
      ##1 mem_cmd.address[15:8] == $past(mem_cmd.address[15:8], 2) &&
      mem_cmd.address[7:0] == 8'($past(mem_cmd.address[7:0], 2) + 8'h01);
  endproperty
  a_pointer_pair: assert property (p_pointer_pair) else $error("pointer second byte wrong");

  property p_pointer_page;
    (state == mem_ref_pkg::ST_PTR_PAGE) && mem_cmd.req |->
      mem_cmd.address[15:8] == (page_select ? program_counter[15:8] : 8'h00);
  endproperty
  a_pointer_page: assert property (p_pointer_page) else $error("pointer page select wrong");

  property p_fetch_advances;
    fetch_ack |=> program_counter == $past(program_counter) + 16'h0001;
  endproperty
  a_fetch_advances: assert property (p_fetch_advances) else $error("counter not advanced");

  property p_select_line;
    ##1 carry_overflow_output_line == $past(select_flag ? overflow_flag : carry_flag);
  endproperty
  a_select_line: assert property (p_select_line) else $error("carry/overflow line wrong");

  property p_load_direct;
    operand_done && (op == mem_ref_pkg::OP_LOAD_DIRECT) |=>
      accumulators[$past(acc_sel)] == $past(mem_rdata);
  endproperty
  a_load_direct: assert property (p_load_direct) else $error("load result wrong");

  property p_store_data;
    mem_cmd.req && mem_cmd.we && (state == mem_ref_pkg::ST_OPERAND) |->
      mem_cmd.wdata == (indirect ? accumulators[0] : accumulators[acc_sel]);
  endproperty
  a_store_data: assert property (p_store_data) else $error("store data wrong");

  property p_add_flags;
    operand_done && (op == mem_ref_pkg::OP_ADD) |=>
      carry_flag == (({1'b0, $past(selected_accumulator)} + {1'b0, $past(mem_rdata)}) > 9'h0ff) &&
      accumulators[$past(acc_sel)] == 8'($past(selected_accumulator) + $past(mem_rdata));
  endproperty
  a_add_flags: assert property (p_add_flags) else $error("add result or carry wrong");

  // signed overflow: equal operand signs and a result sign that differs
  property p_add_overflow;
    operand_done && (op == mem_ref_pkg::OP_ADD) |=>
      overflow_flag == (($past(selected_accumulator[7]) == $past(mem_rdata[7])) &&
                        (accumulators[$past(acc_sel)][7] != $past(selected_accumulator[7])));
  endproperty
  a_add_overflow: assert property (p_add_overflow) else $error("add overflow wrong");

  property p_logic_ops;
    operand_done && ((op == mem_ref_pkg::OP_AND) || (op == mem_ref_pkg::OP_OR)) |=>
      accumulators[0] == ($past(op == mem_ref_pkg::OP_AND) ?
                          ($past(accumulators[0]) & $past(mem_rdata)) :
                          ($past(accumulators[0]) | $past(mem_rdata)));
  endproperty
  a_logic_ops: assert property (p_logic_ops) else $error("logic result wrong");

  // write-back request rises two edges after the operand read is taken
  property p_rmw_write;
    ack && (state == mem_ref_pkg::ST_OPERAND) && rmw_op |=>
      ##1 mem_cmd.req && mem_cmd.we && mem_cmd.address == $past(mem_cmd.address, 2) &&
      mem_cmd.wdata == 8'($past(mem_rdata, 2) +
                          ((op == mem_ref_pkg::OP_INCREMENT_SKIP_ZERO) ? 8'h01 : 8'hff));
  endproperty
  a_rmw_write: assert property (p_rmw_write) else $error("write-back byte wrong");

  property p_subtract;
    operand_done && is_sub |=>
      accumulators[0] == 8'($past(accumulators[0]) - $past(mem_rdata));
  endproperty
  a_subtract: assert property (p_subtract) else $error("subtract result wrong");

  property p_rmw_skip;
    rmw_zero |=> program_counter == $past(program_counter) + 16'h0002;
  endproperty
  a_rmw_skip: assert property (p_rmw_skip) else $error("zero skip missing");

  property p_compare_skip;
    operand_done && (op == mem_ref_pkg::OP_SKIP_NOT_EQUAL) |=>
      program_counter == $past(program_counter) +
        (($past(selected_accumulator) != $past(mem_rdata)) ? 16'h0002 : 16'h0000);
  endproperty
  a_compare_skip: assert property (p_compare_skip) else $error("not-equal skip wrong");

  property p_and_zero_skip;
    operand_done && (op == mem_ref_pkg::OP_SKIP_AND_ZERO) |=>
      program_counter == $past(program_counter) +
        ((($past(accumulators[0]) & $past(mem_rdata)) == 8'h00) ? 16'h0002 : 16'h0000);
  endproperty
  a_and_zero_skip: assert property (p_and_zero_skip) else $error("and-zero skip wrong");

  property p_fetch_order;
    (state == mem_ref_pkg::ST_OPERAND) && !$stable(state) |->
      $past(state) == mem_ref_pkg::ST_FETCH_DISP || $past(state) == mem_ref_pkg::ST_PTR_BYTE;
  endproperty
  a_fetch_order: assert property (p_fetch_order) else $error("operand before fetch");

endmodule

`default_nettype wire

/* memory_reference_instruction_unit_tb.sv */
`timescale 1ns/100ps
`default_nettype none

module memory_reference_instruction_unit_tb;
  logic                   clk_sys = 1'b0;
  logic                   reset_n = 1'b0;
  logic                   select_flag = 1'b0;
  logic [3:0]             ack_delay = 4'h0;
  logic                   mem_ack;
  logic [7:0]             mem_rdata;
  mem_ref_pkg::mem_cmd_s  mem_cmd;
  logic [15:0]            program_counter;
  mem_ref_pkg::acc_bank_t accumulators;
  logic                   carry_flag;
  logic                   overflow_flag;
  logic                   carry_overflow_output_line;
  logic                   unsupported_opcode;
  int                     fail_count = 0;
  int                     samples_checked = 0;
  int                     nop_count = 0;
  logic [7:0]             prog [0:33] = '{8'h88, 8'h82, 8'h8c, 8'h83, 8'h9b, 8'h20,
    8'h80, 8'h80, 8'hf0, 8'h84, 8'hc0, 8'h85, 8'hd1, 8'h86, 8'he4, 8'h87, 8'h80,
    8'h89, 8'hf4, 8'h88, 8'hb0, 8'h8a, 8'he0, 8'h8b, 8'h80, 8'h89, 8'h24, 8'h90,
    8'h35, 8'h92, 8'ha0, 8'h8c, 8'h00, 8'h00};

  always #4 clk_sys = ~clk_sys;

  memory_reference_instruction_unit u_dut (
    .clk_sys                    (clk_sys),
    .reset_n                    (reset_n),
    .mem_ack                    (mem_ack),
    .mem_rdata                  (mem_rdata),
    .select_flag                (select_flag),
    .mem_cmd                    (mem_cmd),
    .program_counter            (program_counter),
    .accumulators               (accumulators),
    .carry_flag                 (carry_flag),
    .overflow_flag              (overflow_flag),
    .carry_overflow_output_line (carry_overflow_output_line),
    .unsupported_opcode         (unsupported_opcode)
  );

  byte_memory_model u_mem (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .mem_cmd   (mem_cmd),
    .ack_delay (ack_delay),
    .mem_ack   (mem_ack),
    .mem_rdata (mem_rdata)
  );

  always @(posedge clk_sys) begin
    if (unsupported_opcode === 1'b1) begin
      nop_count <= nop_count + 1;
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      fail_count++;
    end
  endtask

  // an opcode fetch at target-1 means the instruction before it has finished
  task automatic wait_pc(input logic [15:0] target);
    int n;
    for (n = 0; n < 4000 && program_counter !== target; n++) begin
      @(negedge clk_sys);
    end
    chk(program_counter, target, "pc reached");
  endtask

  initial begin
    fork
      begin
        #200000;
        fail_count++;
        $display("[ERR] %0t watchdog expired", $time);
        finish_test();
      end
    join_none
    for (int a = 0; a < 512; a++) u_mem.mem[a] = 8'h00;
    for (int a = 0; a < 34; a++) u_mem.mem[a] = prog[a];
    u_mem.mem[16'h0080] = 8'h40; u_mem.mem[16'h0082] = 8'h01; u_mem.mem[16'h0083] = 8'hf0;
    u_mem.mem[16'h0084] = 8'hc0; u_mem.mem[16'h0085] = 8'hf1; u_mem.mem[16'h0086] = 8'h0f;
    u_mem.mem[16'h0087] = 8'hff; u_mem.mem[16'h0088] = 8'h02; u_mem.mem[16'h0089] = 8'h55;
    u_mem.mem[16'h008a] = 8'h8f; u_mem.mem[16'h008b] = 8'h70; u_mem.mem[16'h008c] = 8'hc3;
    u_mem.mem[16'h0090] = 8'h01; u_mem.mem[16'h0091] = 8'h50; u_mem.mem[16'h0092] = 8'h01;
    u_mem.mem[16'h0093] = 8'h60; u_mem.mem[16'h0150] = 8'hc3; u_mem.mem[16'h0040] = 8'ha5;
    u_mem.mem[16'h0140] = 8'h5a; u_mem.mem[16'h00fe] = 8'h85; u_mem.mem[16'h00ff] = 8'h40;
    // pointer load on page one: base page would point into unwritten memory
    u_mem.mem[16'h0101] = 8'h25;
    u_mem.mem[16'h0102] = 8'h10;
    u_mem.mem[16'h0111] = 8'h50;
    repeat (4) @(negedge clk_sys);
    reset_n = 1'b1;
    wait_pc(16'h000b);
    chk(accumulators[0], 8'h80, "sub result");
    chk({carry_flag, overflow_flag}, 2'b01, "sub flags");
    $display("test subtract done");
    ack_delay = 4'h3;
    wait_pc(16'h0013);
    chk(accumulators[0], 8'h8f, "and or result");
    chk(u_mem.mem[16'h0087], 8'h00, "increment write back");
    wait_pc(16'h001b);
    chk(accumulators[0], 8'h8f, "skips taken and not taken");
    chk(u_mem.mem[16'h0088], 8'h01, "decrement write back");
    $display("test skips done");
    wait_pc(16'h0021);
    chk(accumulators[0], 8'h86, "add after pointer load");
    chk({carry_flag, overflow_flag}, 2'b10, "add flags");
    chk({accumulators[2], accumulators[3]}, 16'h01f0, "index accs");
    chk(u_mem.mem[16'h0110], 8'h01, "indexed store");
    chk(u_mem.mem[16'h0160], 8'hc3, "pointer store");
    select_flag = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk(carry_overflow_output_line, 1'b0, "line shows overflow");
    select_flag = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk(carry_overflow_output_line, 1'b1, "line shows carry");
    $display("test arithmetic done");
    wait_pc(16'h0101);
    chk(accumulators[1], 8'h5a, "current page after page cross");
    chk(nop_count, 212, "unhandled opcode pulses");
    wait_pc(16'h0104);
    chk(accumulators[0], 8'hc3, "pointer on current page");
    $display("test page cross done");
    reset_n = 1'b0;
    @(negedge clk_sys);
    chk(program_counter, 16'h0000, "pc in reset");
    chk(accumulators, 32'h0, "accs in reset");
    chk(mem_cmd.req, 1'b0, "no request in reset");
    reset_n = 1'b1;
    wait_pc(16'h0001);
    $display("test reset done");
    finish_test();
  end
endmodule
`default_nettype wire
